/* verilog/pfm_pkg.sv */
// Constants and register map of the pin function multiplexer
package pfm_pkg;
	localparam int P0_W = 7;
	localparam int P1_W = 6;
	localparam int P3_W = 2;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;

	typedef enum logic [1:0] {
		PFM_VAR_BASE = 2'h0,
		PFM_VAR_DUAL_CMP = 2'h1,
		PFM_VAR_SERIAL = 2'h2
	} pfm_variant_e;

	localparam logic [ADDR_W-1:0] A_P0_LAT = 4'h0;
	localparam logic [ADDR_W-1:0] A_P1_LAT = 4'h1;
	localparam logic [ADDR_W-1:0] A_P3_LAT = 4'h2;
	localparam logic [ADDR_W-1:0] A_P0_DRV = 4'h3;
	localparam logic [ADDR_W-1:0] A_P1_DRV = 4'h4;
	localparam logic [ADDR_W-1:0] A_P3_DRV = 4'h5;
	localparam logic [ADDR_W-1:0] A_P0_PU = 4'h6;
	localparam logic [ADDR_W-1:0] A_P1_PU = 4'h7;
	localparam logic [ADDR_W-1:0] A_P3_PU = 4'h8;
	localparam logic [ADDR_W-1:0] A_TRIM = 4'h9;
	localparam logic [ADDR_W-1:0] A_UCFG = 4'hA;
	localparam logic [ADDR_W-1:0] A_P0_PIN = 4'hB;
	localparam logic [ADDR_W-1:0] A_P1_PIN = 4'hC;
	localparam logic [ADDR_W-1:0] A_P3_PIN = 4'hD;
	localparam logic [ADDR_W-1:0] A_STATUS = 4'hE;

	// Trim register: clock output enable bit
	localparam int TRIM_DIVIDED_CLOCK_OUTPUT_BIT = 6;
	// User config byte one fields
	localparam int UCFG_OSC_LSB = 0;
	localparam int UCFG_RTC_XTAL_BIT = 2;
	localparam int UCFG_RST_EN_BIT = 3;
	localparam logic [1:0] OSC_RC = 2'h0;
	localparam logic [1:0] OSC_WDT = 2'h1;
	localparam logic [1:0] OSC_EXT = 2'h2;
	localparam logic [1:0] OSC_XTAL = 2'h3;
	// Status register bits
	localparam int ST_ISP_BIT = 0;
	localparam int ST_POR_BIT = 1;
	localparam int ST_CORE_RST_BIT = 2;

	// Pin positions of shared functions
	localparam int P1_RST_BIT = 5;
	localparam int P1_T0_BIT = 2;
	localparam int P1_TX_BIT = 0;
	localparam int P1_RX_BIT = 1;
	localparam int P0_COMPARATOR_TWO_OUTPUT_OUT_BIT = 0;
	localparam int P0_COMPARATOR_ONE_OUTPUT_OUT_BIT = 6;
	localparam int P0_CIN2_BIT = 2;
	localparam int P0_CIN1_BIT = 4;
	localparam int P0_CREF_BIT = 5;
	localparam int P3_XO_BIT = 0;
	localparam int P3_XI_BIT = 1;

	// Reset values
	localparam logic [DATA_W-1:0] LAT_RST = 8'hFF;
	localparam logic [DATA_W-1:0] UCFG_RST = 8'h00;

	// Power-on window in which the shared pin is always a reset input
	localparam int CLK_MHZ = 250;
	localparam int POR_WINDOW_NS = 1000;
	localparam int POR_CYCLES = (POR_WINDOW_NS * CLK_MHZ) / 1000;
	localparam int POR_CNT_W = 16;
	localparam int ISP_CNT_W = 4;
	localparam logic [ISP_CNT_W-1:0] ISP_PULSES = 4'h3;
	// Edges after reset before the shared pin filter and its registered copy both show the true level
	localparam int SYNC_SETTLE = 5;
endpackage : pfm_pkg

/* verilog/pfm_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pfm_sync #(
	parameter int W = 8
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} pfm_sync_s;

	pfm_sync_s s_r;
	pfm_sync_s s_nxt;

	// First stage feeds only the second; a bit is accepted once stages two and three agree
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = d_in;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		for (int i = 0; i < W; i++) begin
			if (s_r.s2[i] == s_r.s3[i]) begin
				s_nxt.q[i] = s_r.s3[i];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q_out = s_r.q;
endmodule : pfm_sync
`default_nettype wire

/* verilog/pfm_mux.sv */
// Pin function multiplexer: port latches, shared pin functions, register port
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pfm_mux
	import pfm_pkg::*;
#(
	parameter pfm_variant_e VARIANT = PFM_VAR_BASE,
	parameter logic [DATA_W-1:0] TRIM_RST = 8'h00,
	parameter int POR_CYC = POR_CYCLES
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [DATA_W-1:0] rdata_out,
	input wire logic [P0_W-1:0] p0_in,
	output logic [P0_W-1:0] p0_out,
	output logic [P0_W-1:0] p0_oe_out,
	output logic [P0_W-1:0] p0_pu_out,
	input wire logic [P1_W-1:0] p1_in,
	output logic [P1_W-1:0] p1_out,
	output logic [P1_W-1:0] p1_oe_out,
	output logic [P1_W-1:0] p1_pu_out,
	input wire logic [P3_W-1:0] p3_in,
	output logic [P3_W-1:0] p3_out,
	output logic [P3_W-1:0] p3_oe_out,
	output logic [P3_W-1:0] p3_pu_out,
	input wire logic comparator_one_output_en_in,
	input wire logic comparator_two_output_en_in,
	input wire logic comparator_one_output_result_in,
	input wire logic comparator_two_output_result_in,
	input wire logic cmp_out_en_in,
	input wire logic t0_ovf_in,
	input wire logic t0_ovf_en_in,
	input wire logic txd_in,
	input wire logic tx_en_in,
	output logic [P0_W-1:0] keypad_out,
	output logic [P0_W-1:0] analog_sel_out,
	output logic timer_zero_count_pin_out,
	output logic rxd_out,
	output logic xtal_enable_out,
	output logic core_reset_out,
	output logic isp_mode_out
);
	typedef struct packed {
		logic [P0_W-1:0] p0_lat;
		logic [P0_W-1:0] p0_drv;
		logic [P0_W-1:0] p0_pu;
		logic [P1_W-1:0] p1_lat;
		logic [P1_W-1:0] p1_drv;
		logic [P1_W-1:0] p1_pu;
		logic [P3_W-1:0] p3_lat;
		logic [P3_W-1:0] p3_drv;
		logic [P3_W-1:0] p3_pu;
		logic [DATA_W-1:0] trim;
		logic [DATA_W-1:0] ucfg;
		logic [DATA_W-1:0] rdata;
		logic [POR_CNT_W-1:0] por_cnt;
		logic por_busy;
		logic [ISP_CNT_W-1:0] isp_cnt;
		logic isp;
		logic rst_prev;
		logic core_rst;
		logic clk_div;
		logic [P0_W-1:0] p0_o;
		logic [P0_W-1:0] p0_oe;
		logic [P0_W-1:0] p0_puo;
		logic [P1_W-1:0] p1_o;
		logic [P1_W-1:0] p1_oe;
		logic [P1_W-1:0] p1_puo;
		logic [P3_W-1:0] p3_o;
		logic [P3_W-1:0] p3_oe;
		logic [P3_W-1:0] p3_puo;
		logic [P0_W-1:0] keypad;
		logic [P0_W-1:0] analog_sel;
		logic t0_cnt;
		logic rxd;
		logic xtal_en;
	} pfm_state_s;

	localparam pfm_state_s STATE_RST = '{
		p0_lat: LAT_RST[P0_W-1:0], p1_lat: LAT_RST[P1_W-1:0], p3_lat: LAT_RST[P3_W-1:0],
		trim: TRIM_RST, ucfg: UCFG_RST, por_busy: 1'b1, core_rst: 1'b1, default: '0
	};
	localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYC - 1);
	// Filter starts low, so an idle-high pin would fake a rising edge; early pulses are lost
	localparam logic [POR_CNT_W-1:0] SETTLE_CNT = POR_CNT_W'(SYNC_SETTLE);

	pfm_state_s s_r;
	pfm_state_s s_nxt;
	logic [P0_W-1:0] p0_sync;
	logic [P1_W-1:0] p1_sync;
	logic [P3_W-1:0] p3_sync;

	pfm_sync #(.W(P0_W)) u_sync_p0 (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(p0_in),
		.q_out(p0_sync));
	pfm_sync #(.W(P1_W)) u_sync_p1 (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(p1_in),
		.q_out(p1_sync));
	pfm_sync #(.W(P3_W)) u_sync_p3 (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(p3_in),
		.q_out(p3_sync));

	// Oscillator field decode, used by several pin decisions
	function automatic logic [1:0] osc_sel(input logic [DATA_W-1:0] cfg);
		osc_sel = cfg[UCFG_OSC_LSB +: 2];
	endfunction : osc_sel

	logic rst_fn;
	logic pin_rst;
	logic xtal_owns_xo;
	logic divided_clock_output_ok;
	logic xi_is_port;

	always_comb begin
		rst_fn = s_r.por_busy | s_r.ucfg[UCFG_RST_EN_BIT];
		pin_rst = rst_fn & ~p1_sync[P1_RST_BIT];
		xtal_owns_xo = (osc_sel(s_r.ucfg) == OSC_XTAL) | s_r.ucfg[UCFG_RTC_XTAL_BIT];
		divided_clock_output_ok = s_r.trim[TRIM_DIVIDED_CLOCK_OUTPUT_BIT] & ~xtal_owns_xo;
		xi_is_port = ((osc_sel(s_r.ucfg) == OSC_RC) | (osc_sel(s_r.ucfg) == OSC_WDT))
			& ~s_r.ucfg[UCFG_RTC_XTAL_BIT];
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = '0;
		s_nxt.rst_prev = p1_sync[P1_RST_BIT];

		// Power-on window: count pin pulses for programming entry
		if (s_r.por_busy) begin
			s_nxt.por_cnt = s_r.por_cnt + 1'b1;
			if (s_r.por_cnt >= SETTLE_CNT && !s_r.rst_prev && p1_sync[P1_RST_BIT]
				&& s_r.isp_cnt != '1) begin
				s_nxt.isp_cnt = s_r.isp_cnt + 1'b1;
			end
			if (s_r.por_cnt == POR_LAST) begin
				s_nxt.por_busy = 1'b0;
				s_nxt.isp = (s_r.isp_cnt >= ISP_PULSES);
			end
		end

		// Each pin owns its own bit, so a write changes only what it addresses
		if (wr_in) begin
			case (addr_in)
				A_P0_LAT: s_nxt.p0_lat = wdata_in[P0_W-1:0];
				A_P1_LAT: s_nxt.p1_lat = wdata_in[P1_W-1:0];
				A_P3_LAT: s_nxt.p3_lat = wdata_in[P3_W-1:0];
				A_P0_DRV: s_nxt.p0_drv = wdata_in[P0_W-1:0];
				A_P1_DRV: s_nxt.p1_drv = wdata_in[P1_W-1:0] & ~(P1_W'(1) << P1_RST_BIT);
				A_P3_DRV: s_nxt.p3_drv = wdata_in[P3_W-1:0];
				A_P0_PU: s_nxt.p0_pu = wdata_in[P0_W-1:0];
				A_P1_PU: s_nxt.p1_pu = wdata_in[P1_W-1:0];
				A_P3_PU: s_nxt.p3_pu = wdata_in[P3_W-1:0];
				A_TRIM: s_nxt.trim = wdata_in;
				A_UCFG: s_nxt.ucfg = wdata_in;
				default: begin
				end
			endcase
		end

		if (rd_in) begin
			case (addr_in)
				A_P0_LAT: s_nxt.rdata = DATA_W'(s_r.p0_lat);
				A_P1_LAT: s_nxt.rdata = DATA_W'(s_r.p1_lat);
				A_P3_LAT: s_nxt.rdata = DATA_W'(s_r.p3_lat);
				A_P0_DRV: s_nxt.rdata = DATA_W'(s_r.p0_drv);
				A_P1_DRV: s_nxt.rdata = DATA_W'(s_r.p1_drv);
				A_P3_DRV: s_nxt.rdata = DATA_W'(s_r.p3_drv);
				A_P0_PU: s_nxt.rdata = DATA_W'(s_r.p0_pu);
				A_P1_PU: s_nxt.rdata = DATA_W'(s_r.p1_pu);
				A_P3_PU: s_nxt.rdata = DATA_W'(s_r.p3_pu);
				A_TRIM: s_nxt.rdata = s_r.trim;
				A_UCFG: s_nxt.rdata = s_r.ucfg;
				A_P0_PIN: s_nxt.rdata = DATA_W'(p0_sync);
				A_P1_PIN: s_nxt.rdata = DATA_W'(p1_sync);
				A_P3_PIN: s_nxt.rdata = DATA_W'(p3_sync);
				A_STATUS: begin
					s_nxt.rdata[ST_ISP_BIT] = s_r.isp;
					s_nxt.rdata[ST_POR_BIT] = s_r.por_busy;
					s_nxt.rdata[ST_CORE_RST_BIT] = s_r.core_rst;
				end
				default: s_nxt.rdata = '0;
			endcase
		end

		// Pin reset wins over a write in the same cycle; config byte survives it
		s_nxt.core_rst = pin_rst;
		if (pin_rst && !s_r.por_busy) begin
			s_nxt.p0_lat = STATE_RST.p0_lat;
			s_nxt.p1_lat = STATE_RST.p1_lat;
			s_nxt.p3_lat = STATE_RST.p3_lat;
			s_nxt.p0_drv = '0;
			s_nxt.p1_drv = '0;
			s_nxt.p3_drv = '0;
			s_nxt.p0_pu = '0;
			s_nxt.p1_pu = '0;
			s_nxt.p3_pu = '0;
			s_nxt.trim = TRIM_RST;
		end

		s_nxt.clk_div = divided_clock_output_ok ? ~s_r.clk_div : 1'b0;

		// Default: latch value through each pin's own output stage
		s_nxt.p0_o = s_r.p0_lat;
		s_nxt.p0_oe = s_r.p0_drv;
		s_nxt.p0_puo = s_r.p0_pu;
		s_nxt.p1_o = s_r.p1_lat;
		s_nxt.p1_oe = s_r.p1_drv;
		s_nxt.p1_puo = s_r.p1_pu;
		s_nxt.p3_o = s_r.p3_lat;
		s_nxt.p3_oe = s_r.p3_drv;
		s_nxt.p3_puo = s_r.p3_pu;

		if (VARIANT == PFM_VAR_DUAL_CMP && cmp_out_en_in) begin
			s_nxt.p0_o[P0_COMPARATOR_TWO_OUTPUT_OUT_BIT] = comparator_two_output_result_in;
			s_nxt.p0_oe[P0_COMPARATOR_TWO_OUTPUT_OUT_BIT] = 1'b1;
			s_nxt.p0_o[P0_COMPARATOR_ONE_OUTPUT_OUT_BIT] = comparator_one_output_result_in;
			s_nxt.p0_oe[P0_COMPARATOR_ONE_OUTPUT_OUT_BIT] = 1'b1;
		end
		if (VARIANT == PFM_VAR_BASE && t0_ovf_en_in) begin
			s_nxt.p1_o[P1_T0_BIT] = t0_ovf_in;
			s_nxt.p1_oe[P1_T0_BIT] = 1'b1;
		end
		if (VARIANT == PFM_VAR_SERIAL && tx_en_in) begin
			s_nxt.p1_o[P1_TX_BIT] = txd_in;
			s_nxt.p1_oe[P1_TX_BIT] = 1'b1;
		end
		// Shared reset pin never drives, whatever the latches hold
		s_nxt.p1_o[P1_RST_BIT] = 1'b0;
		s_nxt.p1_oe[P1_RST_BIT] = 1'b0;
		s_nxt.p1_puo[P1_RST_BIT] = 1'b0;

		if (VARIANT == PFM_VAR_BASE) begin
			if (xtal_owns_xo) begin
				s_nxt.p3_oe[P3_XO_BIT] = 1'b0;
				s_nxt.p3_puo[P3_XO_BIT] = 1'b0;
			end else if (divided_clock_output_ok) begin
				s_nxt.p3_o[P3_XO_BIT] = s_r.clk_div;
				s_nxt.p3_oe[P3_XO_BIT] = 1'b1;
			end
			if (!xi_is_port) begin
				s_nxt.p3_oe[P3_XI_BIT] = 1'b0;
				s_nxt.p3_puo[P3_XI_BIT] = 1'b0;
			end
		end
		s_nxt.xtal_en = (VARIANT == PFM_VAR_BASE) && xtal_owns_xo;

		// Digital input buffers shut off on pins the comparators use as analog inputs
		s_nxt.analog_sel = '0;
		s_nxt.analog_sel[P0_CIN1_BIT] = comparator_one_output_en_in;
		s_nxt.analog_sel[P0_CIN2_BIT] = comparator_two_output_en_in;
		s_nxt.analog_sel[P0_CREF_BIT] = comparator_one_output_en_in | comparator_two_output_en_in;
		s_nxt.keypad = p0_sync;
		s_nxt.t0_cnt = (VARIANT == PFM_VAR_BASE) ? p1_sync[P1_T0_BIT] : 1'b0;
		s_nxt.rxd = (VARIANT == PFM_VAR_SERIAL) ? p1_sync[P1_RX_BIT] : 1'b1;
	end

	// Power-on reset: input-only, pull-ups off, clock output off
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_out = s_r.rdata;
	assign p0_out = s_r.p0_o;
	assign p0_oe_out = s_r.p0_oe;
	assign p0_pu_out = s_r.p0_puo;
	assign p1_out = s_r.p1_o;
	assign p1_oe_out = s_r.p1_oe;
	assign p1_pu_out = s_r.p1_puo;
	assign p3_out = s_r.p3_o;
	assign p3_oe_out = s_r.p3_oe;
	assign p3_pu_out = s_r.p3_puo;
	assign keypad_out = s_r.keypad;
	assign analog_sel_out = s_r.analog_sel;
	assign timer_zero_count_pin_out = s_r.t0_cnt;
	assign rxd_out = s_r.rxd;
	assign xtal_enable_out = s_r.xtal_en;
	assign core_reset_out = s_r.core_rst;
	assign isp_mode_out = s_r.isp;

	AST_RESET_INPUT_ONLY: assert property (
		@(posedge clk_in) !nrst_in |=> (p0_oe_out == '0 && p1_oe_out == '0 && p3_oe_out == '0
			&& p0_pu_out == '0 && p1_pu_out == '0 && p3_pu_out == '0))
		else $error("port driven or pulled up right after reset");

	AST_DRV_ONE_BIT: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(wr_in && addr_in == A_P0_DRV && !pin_rst) |=> s_r.p0_drv == $past(wdata_in[P0_W-1:0]))
		else $error("drive write did not land bit for bit");

	AST_RST_PIN_NO_DRIVE: assert property (
		@(posedge clk_in) disable iff (!nrst_in) !p1_oe_out[P1_RST_BIT] && !s_r.p1_drv[P1_RST_BIT])
		else $error("shared reset pin driver enabled");

	AST_PIN_RESET_GATED: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(!s_r.por_busy && !s_r.ucfg[UCFG_RST_EN_BIT]) |=> !core_reset_out)
		else $error("shared pin reset without selection");

	AST_PIN_RESET_CLEARS: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(pin_rst && !s_r.por_busy) |=> (core_reset_out && s_r.p1_drv == '0
			&& s_r.p0_pu == '0 && s_r.trim == TRIM_RST) ##1 p1_pu_out == '0)
		else $error("pin reset left ports configured");

	AST_ISP_DECIDE: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		$fell(s_r.por_busy) |-> (isp_mode_out == ($past(s_r.isp_cnt) >= ISP_PULSES)))
		else $error("programming entry decision wrong");

	AST_DIVIDED_CLOCK_OUTPUT_TOGGLES: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(VARIANT == PFM_VAR_BASE && divided_clock_output_ok && $past(divided_clock_output_ok)) |=>
			(p3_oe_out[P3_XO_BIT] && p3_out[P3_XO_BIT] != $past(p3_out[P3_XO_BIT])))
		else $error("clock output not at half rate");

	AST_XO_RELEASED: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(VARIANT == PFM_VAR_BASE && xtal_owns_xo) |=> (!p3_oe_out[P3_XO_BIT] && xtal_enable_out))
		else $error("crystal output pin still driven");

	AST_XI_PORT: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(VARIANT == PFM_VAR_BASE && !xi_is_port) |=> !p3_oe_out[P3_XI_BIT])
		else $error("oscillator input pin driven");

	AST_TX_ROUTE: assert property (
		@(posedge clk_in) disable iff (!nrst_in)
		(VARIANT == PFM_VAR_SERIAL && tx_en_in) |=>
			(p1_oe_out[P1_TX_BIT] && p1_out[P1_TX_BIT] == $past(txd_in)))
		else $error("transmit data not on pin");

	AST_KEYPAD_FOLLOWS: assert property (
		@(posedge clk_in) disable iff (!nrst_in) ##1 keypad_out == $past(p0_sync))
		else $error("keypad input not taken from port 0");
endmodule : pfm_mux
`default_nettype wire

/* tb/pfm_board.sv */
// Board model: resolves the level of each pad of one port
`timescale 1ns/1ns
`default_nettype none
module pfm_board #(
	parameter int W = 2
) (
	input wire logic clk_in,
	input wire logic [W-1:0] out_in,
	input wire logic [W-1:0] oe_in,
	input wire logic [W-1:0] pu_in,
	input wire logic [W-1:0] ext_en_in,
	input wire logic [W-1:0] ext_val_in,
	output logic [W-1:0] pad_out
);
	// A floating pad wanders every cycle so a stale level never looks valid
	logic [W-1:0] float_r = '0;
	always_ff @(posedge clk_in) begin
		float_r <= ~float_r;
	end
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (oe_in[i]) begin
				pad_out[i] = out_in[i];
			end else if (ext_en_in[i]) begin
				pad_out[i] = ext_val_in[i];
			end else if (pu_in[i]) begin
				pad_out[i] = 1'b1;
			end else begin
				pad_out[i] = float_r[i];
			end
		end
	end
endmodule : pfm_board
`default_nettype wire

/* tb/pfm_mux_tb_top.sv */
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ns
`default_nettype none
module pfm_mux_tb_top;
	import pfm_pkg::*;
	localparam int POR = 40;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [6:0] p0_i, p0_o, p0_oe, p0_pu, keypad, analog;
	logic [5:0] p1_i, p1_o, p1_oe, p1_pu;
	logic [1:0] p3_i, p3_o, p3_oe, p3_pu;
	logic [6:0] p0_val = 7'h00;
	logic [5:0] p1_val = 6'h20;
	logic comparator_one_output_en = 1'b0;
	logic comparator_two_output_en = 1'b0;
	logic t0_ovf = 1'b0;
	logic t0_en = 1'b0;
	logic tx_en = 1'b0;
	logic cmp_oe = 1'b0;
	logic [6:0] p0_ext = 7'h7F;
	logic [5:0] p1_ext = 6'h3F;
	logic [1:0] p3_ext = 2'h0;
	logic [1:0] p3_val = 2'h0;
	logic tz, rxd, xtal_en, core_rst, isp, b;
	int fail_count = 0;
	int samples_checked = 0;
	logic [7:0] ucfg_tab [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
	logic [1:0] oe_tab [5] = '{2'h3, 2'h3, 2'h1, 2'h0, 2'h0};

	pfm_mux #(.VARIANT(PFM_VAR_BASE), .POR_CYC(POR)) i_dut (
		.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
		.p0_in(p0_i), .p0_out(p0_o), .p0_oe_out(p0_oe), .p0_pu_out(p0_pu),
		.p1_in(p1_i), .p1_out(p1_o), .p1_oe_out(p1_oe), .p1_pu_out(p1_pu),
		.p3_in(p3_i), .p3_out(p3_o), .p3_oe_out(p3_oe), .p3_pu_out(p3_pu),
		.comparator_one_output_en_in(comparator_one_output_en), .comparator_two_output_en_in(comparator_two_output_en), .comparator_one_output_result_in(1'b0),
		.comparator_two_output_result_in(1'b0), .cmp_out_en_in(cmp_oe), .t0_ovf_in(t0_ovf),
		.t0_ovf_en_in(t0_en), .txd_in(1'b1), .tx_en_in(tx_en), .keypad_out(keypad),
		.analog_sel_out(analog), .timer_zero_count_pin_out(tz), .rxd_out(rxd),
		.xtal_enable_out(xtal_en), .core_reset_out(core_rst), .isp_mode_out(isp)
	);
	pfm_board #(.W(7)) i_b0 (.clk_in(clk_in), .out_in(p0_o), .oe_in(p0_oe), .pu_in(p0_pu),
		.ext_en_in(p0_ext), .ext_val_in(p0_val), .pad_out(p0_i));
	pfm_board #(.W(6)) i_b1 (.clk_in(clk_in), .out_in(p1_o), .oe_in(p1_oe), .pu_in(p1_pu),
		.ext_en_in(p1_ext), .ext_val_in(p1_val), .pad_out(p1_i));
	pfm_board #(.W(2)) i_b3 (.clk_in(clk_in), .out_in(p3_o), .oe_in(p3_oe), .pu_in(p3_pu),
		.ext_en_in(p3_ext), .ext_val_in(p3_val), .pad_out(p3_i));

	initial begin
		forever #2 clk_in = ~clk_in;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc

	task automatic rst();
		@(posedge clk_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		#1;
	endtask : rst

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask : rdchk

	// Shared pin pulses: four cycles low, then four high; leaves the pin high
	task automatic rst_pin_pulses(input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge clk_in);
			p1_val[5] <= 1'b0;
			repeat (4) @(posedge clk_in);
			p1_val[5] <= 1'b1;
			repeat (3) @(posedge clk_in);
		end
	endtask : rst_pin_pulses

	// Bounded wait on the core reset level; a miss ends the run
	task automatic wait_core(input logic v);
		int n;
		n = 0;
		while (core_rst !== v && n < 20) begin
			cyc(1);
			n++;
		end
		chk("core reset", {7'h0, v}, {7'h0, core_rst});
		if (core_rst !== v) end_of_test();
	endtask : wait_core

	function automatic logic [7:0] pmask(input int p);
		int w;
		w = (p == 0) ? P0_W : (p == 1) ? P1_W : P3_W;
		return LAT_RST & 8'((1 << w) - 1);
	endfunction : pmask

	initial begin
		rst();
		chk("p0 oe pu", 8'h00, {1'b0, p0_oe | p0_pu});
		chk("p1 oe pu", 8'h00, {2'b0, p1_oe | p1_pu});
		chk("p3 oe pu", 8'h00, {6'b0, p3_oe | p3_pu});
		for (int i = 0; i < 9; i++) begin
			rdchk("reset reg", 4'(i), (i < 3) ? pmask(i % 3) : 8'h00);
		end
		rst_pin_pulses(2);
		cyc(POR + 10);
		chk("isp", 8'h00, {7'h0, isp});
		rdchk("status", A_STATUS, 8'h00);
		$display("test reset done");
		wr(A_P0_LAT, 8'h00);
		wr(A_P0_DRV, 8'h01);
		wr(A_P0_PU, 8'h04);
		cyc(2);
		chk("p0 oe", 8'h01, {1'b0, p0_oe});
		chk("p0 pu", 8'h04, {1'b0, p0_pu});
		chk("p0 out0", 8'h00, {7'h0, p0_o[0]});
		rdchk("p1 drv", A_P1_DRV, 8'h00);
		wr(A_P1_DRV, 8'h3F);
		rdchk("p1 drv", A_P1_DRV, 8'h1F);
		cyc(2);
		chk("p1 oe", 8'h1F, {2'b0, p1_oe});
		$display("test config done");
		wr(A_P1_LAT, 8'h00);
		@(posedge clk_in);
		t0_en <= 1'b1;
		t0_ovf <= 1'b1;
		cyc(2);
		chk("t0 pin", 8'h01, {7'h0, p1_o[2]});
		@(posedge clk_in);
		t0_ovf <= 1'b0;
		cyc(2);
		chk("t0 pin", 8'h00, {7'h0, p1_o[2]});
		wr(A_P1_DRV, 8'h00);
		@(posedge clk_in);
		t0_en <= 1'b0;
		p1_val[2] <= 1'b1;
		cyc(6);
		chk("count pin", 8'h01, {7'h0, tz});
		@(posedge clk_in);
		p1_val[2] <= 1'b0;
		cyc(6);
		chk("count pin", 8'h00, {7'h0, tz});
		// Pin 0 is driven low by the block, so the block's driver wins over the board
		@(posedge clk_in);
		p0_val <= 7'h55;
		cyc(6);
		chk("keypad", 8'h54, {1'b0, keypad});
		rdchk("p0 pins", A_P0_PIN, 8'h54);
		@(posedge clk_in);
		comparator_one_output_en <= 1'b1;
		cyc(2);
		chk("analog", 8'h30, {1'b0, analog});
		@(posedge clk_in);
		comparator_one_output_en <= 1'b0;
		comparator_two_output_en <= 1'b1;
		cyc(2);
		chk("analog", 8'h24, {1'b0, analog});
		// Base variant owns neither serial nor comparator outputs
		@(posedge clk_in);
		tx_en <= 1'b1;
		cmp_oe <= 1'b1;
		cyc(2);
		chk("p1 oe", 8'h00, {2'b0, p1_oe});
		chk("p0 oe", 8'h01, {1'b0, p0_oe});
		chk("rxd", 8'h01, {7'h0, rxd});
		$display("test alternate done");
		wr(A_P3_LAT, 8'h00);
		wr(A_P3_DRV, 8'h03);
		wr(A_TRIM, 8'h40);
		for (int i = 0; i < 5; i++) begin
			wr(A_UCFG, ucfg_tab[i]);
			cyc(3);
			chk("p3 oe", {6'h0, oe_tab[i]}, {6'h0, p3_oe});
			chk("xtal", {7'h0, i >= 3}, {7'h0, xtal_en});
			b = p3_o[0];
			cyc(1);
			if (oe_tab[i][0]) chk("clock out", {7'h0, ~b}, {7'h0, p3_o[0]});
		end
		@(posedge clk_in);
		p3_ext <= 2'h3;
		p3_val <= 2'h2;
		cyc(6);
		rdchk("p3 pins", A_P3_PIN, 8'h02);
		$display("test clock done");
		wr(A_UCFG, 8'h00);
		@(posedge clk_in);
		p1_val[5] <= 1'b0;
		cyc(10);
		chk("core reset", 8'h00, {7'h0, core_rst});
		rdchk("p0 drv", A_P0_DRV, 8'h01);
		@(posedge clk_in);
		p1_val[5] <= 1'b1;
		cyc(6);
		wr(A_UCFG, 8'h08);
		@(posedge clk_in);
		p1_val[5] <= 1'b0;
		wait_core(1'b1);
		cyc(2);
		rdchk("p0 drv", A_P0_DRV, 8'h00);
		rdchk("p1 lat", A_P1_LAT, pmask(1));
		rdchk("trim", A_TRIM, 8'h00);
		rdchk("ucfg", A_UCFG, 8'h08);
		chk("p0 oe", 8'h00, {1'b0, p0_oe});
		@(posedge clk_in);
		p1_val[5] <= 1'b1;
		wait_core(1'b0);
		$display("test pin reset done");
		@(posedge clk_in);
		p1_val[5] <= 1'b0;
		rst();
		cyc(2);
		chk("core reset", 8'h01, {7'h0, core_rst});
		rst_pin_pulses(3);
		cyc(POR);
		wait_core(1'b0);
		chk("isp", 8'h01, {7'h0, isp});
		rdchk("status", A_STATUS, 8'h01);
		$display("test programming entry done");
		end_of_test();
	end
endmodule : pfm_mux_tb_top
`default_nettype wire
